/* core/adcpm_defs.svh */
// timing counts, mode encodings and coding constants for the power-mode block
`ifndef ADCPM_DEFS_SVH
`define ADCPM_DEFS_SVH

`define ADCPM_CLK_MHZ 100
`define ADCPM_WAKE_NS 5000
// least wake time rounds up to whole mclk cycles
`define ADCPM_WAKE_CYC ((`ADCPM_WAKE_NS * `ADCPM_CLK_MHZ + 999) / 1000)
// conversion length in half periods of the converter clock (16.5 periods)
`define ADCPM_CONV_HALVES 33
`define ADCPM_PM_UP 2'b00
`define ADCPM_PM_PDBC 2'b01
`define ADCPM_PM_FULLPD 2'b10
`define ADCPM_PM_PARTBC 2'b11
`define ADCPM_RES_W 12
`define ADCPM_MIDSCALE 12'h800

`endif

/* core/adcpm_pkg.sv */
// types shared by the power-mode and coding block
package adcpm_pkg;
    typedef enum logic [2:0] {
        ADCPM_POWER_ON = 3'b001,
        ADCPM_POWER_FULL_OFF = 3'b010,
        ADCPM_POWER_PART_OFF = 3'b100
    } adcpm_power_t;

    typedef struct packed {
        logic core_en;
        logic ref_en;
    } adcpm_supply_t;
endpackage : adcpm_pkg

/* core/adcpm_sync.sv */
// three-flop synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
`default_nettype none
module adcpm_sync (
    input wire logic mclk,
    input wire logic rst,
    input wire logic pin_in,
    output var logic level_out
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    // capture chain; s1 feeds only s2
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    // output follows once the second and third stages agree
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            level_out <= 1'b1;
        end else if (s2_reg == s3_reg) begin
            level_out <= s3_reg;
        end
    end
endmodule : adcpm_sync
`default_nettype wire

/* core/adcpm_ctrl.sv */
// power-mode selection, conversion timing and output coding for the converter
`timescale 1ns/10ps
`default_nettype none
`include "adcpm_defs.svh"
// ============================================================
// power-mode and coding control
module adcpm_ctrl
    import adcpm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic pwr_mgmt_wr,
    input wire logic pwr_mgmt_hi,
    input wire logic pwr_mgmt_lo,
    input wire logic sleep_n_pin,
    input wire logic conversion_start_pin,
    input wire logic master_clock_in,
    input wire logic bipolar_sel,
    input wire logic [11:0] raw_result,
    output var logic busy,
    output var logic ready,
    output var logic core_power_en,
    output var logic ref_power_en,
    output var logic [11:0] result_out,
    output var logic result_valid,
    output var logic [2:0] power_state
);
    // ============================================================
    // pin synchronisers
    logic sleep_n_s;
    logic cs_s;
    logic cclk_s;
    adcpm_sync u_sync_sleep (
        .mclk(mclk),
        .rst(rst),
        .pin_in(sleep_n_pin),
        .level_out(sleep_n_s)
    );
    adcpm_sync u_sync_cs (
        .mclk(mclk),
        .rst(rst),
        .pin_in(conversion_start_pin),
        .level_out(cs_s)
    );
    adcpm_sync u_sync_clk (
        .mclk(mclk),
        .rst(rst),
        .pin_in(master_clock_in),
        .level_out(cclk_s)
    );

    // ============================================================
    // management bits register
    logic [1:0] pm_reg;
    // hold bits until overwritten; zero after reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pm_reg <= 2'b00;
        end else if (pwr_mgmt_wr) begin
            pm_reg <= {pwr_mgmt_hi, pwr_mgmt_lo};
        end
    end

    // ============================================================
    // mode decode
    wire is_up = (pm_reg == `ADCPM_PM_UP) && sleep_n_s;
    wire is_full_bc = ((pm_reg == `ADCPM_PM_UP) && !sleep_n_s)
        || (pm_reg == `ADCPM_PM_PDBC);
    wire is_full_pd = (pm_reg == `ADCPM_PM_FULLPD);
    wire is_part_bc = (pm_reg == `ADCPM_PM_PARTBC);

    // ============================================================
    // edge detection on synchronised pins
    logic cs_d_reg;
    logic cclk_d_reg;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cs_d_reg <= 1'b1;
            cclk_d_reg <= 1'b1;
        end else begin
            cs_d_reg <= cs_s;
            cclk_d_reg <= cclk_s;
        end
    end
    wire cs_fall = cs_d_reg && !cs_s;
    wire cs_rise = !cs_d_reg && cs_s;
    wire cclk_edge = cclk_d_reg != cclk_s;
    wire cclk_fall = cclk_d_reg && !cclk_s;

    // ============================================================
    // power state machine
    adcpm_power_t state_reg;
    adcpm_power_t state_next;
    logic [9:0] wake_reg;
    logic [9:0] wake_next;
    logic [5:0] half_reg;
    logic [5:0] half_next;
    logic armed_reg;
    logic armed_next;
    logic busy_reg;
    logic busy_next;
    wire conv_done = busy_reg && cclk_edge && (half_reg == 6'd1);

    // state, wake timer and conversion counter
    always_comb begin
        state_next = state_reg;
        wake_next = wake_reg;
        half_next = half_reg;
        armed_next = armed_reg;
        busy_next = busy_reg;
        // power state per present state
        case (state_reg)
            ADCPM_POWER_ON: begin
                // a finished conversion drops into the selected sleep state
                if (conv_done && is_full_bc) begin
                    state_next = ADCPM_POWER_FULL_OFF;
                end else if (conv_done && is_part_bc) begin
                    state_next = ADCPM_POWER_PART_OFF;
                end
            end
            ADCPM_POWER_FULL_OFF, ADCPM_POWER_PART_OFF: begin
                // start falling edge wakes the core unless held fully down
                if (cs_fall && !is_full_pd) begin
                    state_next = ADCPM_POWER_ON;
                end
            end
            default: begin
                state_next = ADCPM_POWER_ON;
            end
        endcase
        // wake timer: loaded on a waking edge, ready once it runs out
        if (cs_fall && state_reg != ADCPM_POWER_ON && !is_full_pd) begin
            wake_next = 10'(`ADCPM_WAKE_CYC);
        end else if (wake_reg != 10'd0) begin
            wake_next = wake_reg - 10'd1;
        end
        // rising start edge arms; conversion begins at next clock fall
        if (cs_rise && !busy_reg && state_reg == ADCPM_POWER_ON) begin
            armed_next = 1'b1;
        end
        if (armed_reg && cclk_fall) begin
            armed_next = 1'b0;
            busy_next = 1'b1;
            half_next = 6'(`ADCPM_CONV_HALVES);
        end else if (busy_reg && cclk_edge) begin
            half_next = half_reg - 6'd1;
            if (half_reg == 6'd1) begin
                busy_next = 1'b0;
            end
        end
        // mode driven transitions
        if (is_full_pd) begin
            state_next = ADCPM_POWER_FULL_OFF;
            busy_next = 1'b0;
            armed_next = 1'b0;
        end else if (is_up) begin
            state_next = ADCPM_POWER_ON;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= ADCPM_POWER_ON;
            wake_reg <= 10'd0;
            half_reg <= 6'd0;
            armed_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            wake_reg <= wake_next;
            half_reg <= half_next;
            armed_reg <= armed_next;
            busy_reg <= busy_next;
        end
    end

    // ============================================================
    // supply enables
    adcpm_supply_t sup;
    assign sup.core_en = (state_reg == ADCPM_POWER_ON);
    assign sup.ref_en = (state_reg != ADCPM_POWER_FULL_OFF);

    // ============================================================
    // output coding
    function automatic logic [11:0] code_result(input logic bip, input logic [11:0] raw);
        code_result = bip ? (raw ^ `ADCPM_MIDSCALE) : raw;
    endfunction : code_result

    logic [11:0] result_reg;
    logic valid_reg;
    // latch coded result as conversion ends
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            result_reg <= 12'h000;
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= conv_done;
            if (conv_done) begin
                result_reg <= code_result(bipolar_sel, raw_result);
            end
        end
    end

    assign busy = busy_reg;
    assign ready = (state_reg == ADCPM_POWER_ON) && (wake_reg == 10'd0);
    assign core_power_en = sup.core_en;
    assign ref_power_en = sup.ref_en;
    assign result_out = result_reg;
    assign result_valid = valid_reg;
    assign power_state = state_reg;
endmodule : adcpm_ctrl
`default_nettype wire

/* testbench/adcpm_ctrl_asserts.sv */
// checker for rails, conversion flags and result coding
`timescale 1ns/10ps
`default_nettype none
`include "adcpm_defs.svh"
module adcpm_ctrl_asserts (
    input wire logic mclk,
    input wire logic rst,
    input wire logic bipolar_sel,
    input wire logic [11:0] raw_result,
    input wire logic busy,
    input wire logic ready,
    input wire logic core_power_en,
    input wire logic ref_power_en,
    input wire logic [11:0] result_out,
    input wire logic result_valid,
    input wire logic [2:0] power_state
);
    // ==========
    // properties
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    chk_full_off_rails: assert property (
        power_state == 3'h2 |-> !core_power_en && !ref_power_en) else $error("rails on");
    chk_part_off_ref: assert property (
        power_state == 3'h4 |-> !core_power_en && ref_power_en) else $error("bad rails");
    chk_busy_powered: assert property (
        busy |-> power_state == 3'h1 && core_power_en) else $error("busy while off");
    chk_ready_powered: assert property (
        ready |-> power_state == 3'h1) else $error("ready while off");
    chk_done_valid: assert property (
        $fell(busy) |-> ##[0:1] result_valid) else $error("no result at end");
    chk_valid_pulse: assert property (
        result_valid |=> !result_valid) else $error("valid too long");
    chk_busy_min_len: assert property (
        $rose(busy) |-> busy [*8]) else $error("busy too short");
    chk_result_coding: assert property (
        $fell(result_valid) |-> result_out === (bipolar_sel ?
        raw_result ^ `ADCPM_MIDSCALE : raw_result)) else $error("bad coding");
    cover property ($fell(busy) ##[1:3] power_state == 3'h4);
    cover property ($fell(busy) ##[1:3] power_state == 3'h2);
    cover property (result_valid && bipolar_sel);
endmodule : adcpm_ctrl_asserts
`default_nettype wire

/* testbench/adcpm_host.sv */
// host model: bit writes, start pulses, converter clock
`timescale 1ns/10ps
`default_nettype none
module adcpm_host (
    input wire logic mclk,
    output var logic pwr_mgmt_wr,
    output var logic pwr_mgmt_hi,
    output var logic pwr_mgmt_lo,
    output var logic conversion_start_pin,
    output var logic master_clock_in
);
    logic [1:0] div_reg;
    // ==========
    // converter clock, eight mclk cycles a period
    initial begin
        {pwr_mgmt_wr, pwr_mgmt_hi, pwr_mgmt_lo} = 3'h0;
        conversion_start_pin = 1'b1;
    end
    // one process owns the divider and the clock pin
    initial begin
        div_reg = 2'h0;
        master_clock_in = 1'b0;
        forever begin
            @(negedge mclk);
            div_reg = div_reg + 2'h1;
            if (div_reg == 2'h0) master_clock_in = ~master_clock_in;
        end
    end
    // one-cycle write of both management bits
    task automatic write_bits(input logic hi, input logic lo);
        @(negedge mclk);
        {pwr_mgmt_hi, pwr_mgmt_lo, pwr_mgmt_wr} = {hi, lo, 1'b1};
        @(negedge mclk);
        pwr_mgmt_wr = 1'b0;
    endtask : write_bits
    // start pulse held low past the wake time
    task automatic start_pulse();
        @(negedge mclk);
        conversion_start_pin = 1'b0;
        repeat (520) @(negedge mclk);
        conversion_start_pin = 1'b1;
    endtask : start_pulse
endmodule : adcpm_host
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the power-mode and coding block
`timescale 1ns/10ps
`default_nettype none
`include "adcpm_defs.svh"
module testbench;
    typedef struct packed {
        logic [1:0] b;
        logic s;
        logic p;
        logic [11:0] r;
        logic [2:0] st;
    } adcpm_row_t;
    localparam adcpm_row_t ROWS [5] = '{
        '{2'h0, 1'b1, 1'b0, 12'h123, 3'h1},
        '{2'h0, 1'b0, 1'b0, 12'hfff, 3'h2},
        '{2'h1, 1'b1, 1'b1, 12'h000, 3'h2},
        '{2'h3, 1'b1, 1'b1, 12'h7ff, 3'h4},
        '{2'h0, 1'b1, 1'b0, 12'h800, 3'h1}};
    logic mclk, rst, wr, hi, lo, sleep_n_pin, cs_n, mck, bipolar_sel, busy, ready, cen, ren, vld;
    logic [11:0] raw_result, result_out;
    logic [2:0] power_state;
    int n_errors, checked, nb;
    adcpm_host i_adcpm_host (.mclk(mclk), .pwr_mgmt_wr(wr), .pwr_mgmt_hi(hi), .pwr_mgmt_lo(lo),
        .conversion_start_pin(cs_n), .master_clock_in(mck));
    adcpm_ctrl i_adcpm_ctrl (.mclk(mclk), .rst(rst), .pwr_mgmt_wr(wr), .pwr_mgmt_hi(hi),
        .pwr_mgmt_lo(lo), .sleep_n_pin(sleep_n_pin), .conversion_start_pin(cs_n),
        .master_clock_in(mck), .bipolar_sel(bipolar_sel), .raw_result(raw_result), .busy(busy),
        .ready(ready), .core_power_en(cen), .ref_power_en(ren), .result_out(result_out),
        .result_valid(vld), .power_state(power_state));
    // ==========
    // clock, checks and closing
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("checked %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test
    // one pulse-started conversion, then the state it leaves
    task automatic convert(input logic [2:0] st);
        i_adcpm_host.start_pulse();
        check(ready, 1'b1);
        nb = 0;
        while (!busy && nb < 200) begin
            @(negedge mclk);
            nb++;
        end
        nb = 0;
        while (busy && nb < 400) begin
            @(negedge mclk);
            nb++;
        end
        check(nb >= 128 && nb <= 136, 1'b1);
        check(vld, 1'b1);
        repeat (3) @(negedge mclk);
        check({power_state, cen, ren}, {st, st == 3'h1, st != 3'h2});
    endtask : convert
    initial begin
        {rst, sleep_n_pin, bipolar_sel, raw_result} = {2'h3, 13'h0};
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        check({power_state, busy, ready, cen, ren}, 7'h17);
        for (int i = 0; i < 5; i++) begin
            i_adcpm_host.write_bits(ROWS[i].b[1], ROWS[i].b[0]);
            {sleep_n_pin, bipolar_sel, raw_result} = {ROWS[i].s, ROWS[i].p, ROWS[i].r};
            repeat (6) @(negedge mclk);
            convert(ROWS[i].st);
            check(result_out, ROWS[i].r ^ {ROWS[i].p, 11'h0});
        end
        i_adcpm_host.write_bits(1'b1, 1'b0);
        repeat (6) @(negedge mclk);
        check({power_state, cen, ren}, 5'h08);
        i_adcpm_host.start_pulse();
        check({ready, busy}, 2'h0);
        i_adcpm_host.write_bits(1'b0, 1'b0);
        repeat (2) @(negedge mclk);
        check(power_state, 3'h1);
        i_adcpm_host.write_bits(1'b1, 1'b1);
        rst = 1'b1;
        @(negedge mclk);
        rst = 1'b0;
        repeat (6) @(negedge mclk);
        convert(3'h1);
        end_of_test();
    end
    initial begin
        #200000;
        n_errors++;
        end_of_test();
    end
endmodule : testbench
bind adcpm_ctrl adcpm_ctrl_asserts i_adcpm_ctrl_asserts (.mclk(mclk), .rst(rst),
    .bipolar_sel(bipolar_sel), .raw_result(raw_result), .busy(busy), .ready(ready),
    .core_power_en(core_power_en), .ref_power_en(ref_power_en), .result_out(result_out),
    .result_valid(result_valid), .power_state(power_state));
`default_nettype wire
